// [bench/host_ctl.sv]
module host_ctl (
    input wire core_clk,
    input wire [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [8:0] reg_addr,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 16'h0000;
    end
    // Released write data is inverted so stale values cannot pass
    task automatic wr(input [8:0] a, input [15:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input [8:0] a, output [15:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule // host_ctl

// [bench/sha_auth_assertions.sv]
`include "sha_auth_regs.vh"

module sha_auth_checker #(
    parameter HASH_CYC = 8,
    parameter STORE_CYC = 8
) (
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    input wire reg_wr,
    input wire reg_rd,
    input wire [8:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire nvm_write_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACT_MAX = HASH_CYC + STORE_CYC + 4;
    reg [15:0] since_cmd_r;
    wire st_rd = clk_en && reg_rd && reg_addr == `ADDR_PROT_STAT;
    wire unl_wr = clk_en && reg_wr && reg_addr == `ADDR_PROT_STAT
        && reg_wdata == `STAT_UNLOCK_VAL;
    wire idle = !reg_wr && !reg_rd;
    // Saturates so that a long quiet spell never wraps back into range
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            since_cmd_r <= 16'hFFFF;
        else if (clk_en && reg_wr && reg_addr == `ADDR_COMMAND)
            since_cmd_r <= 16'h0000;
        else if (clk_en && since_cmd_r != 16'hFFFF)
            since_cmd_r <= since_cmd_r + 16'h0001;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence unlock_pair;
        unl_wr ##1 idle ##1 unl_wr;
    endsequence
    sequence then_status;
        idle ##1 st_rd;
    endsequence
    a_rdata_idle_zero: assert property (
        clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero without a read");
    a_cmd_read_zero: assert property (
        clk_en && reg_rd && reg_addr == `ADDR_COMMAND
        |=> reg_rdata == 16'h0000)
        else $error("command register readable");
    a_stat_upper_zero: assert property (st_rd |=> reg_rdata[15:8] == 8'h00)
        else $error("status upper byte not zero");
    a_rdata_frozen: assert property (!clk_en |=> $stable(reg_rdata))
        else $error("read data moved while clock enable low");
    a_gap_unmapped: assert property (clk_en && reg_rd && reg_addr > 9'h061
        && reg_addr < `ADDR_BUF_FIRST |=> reg_rdata == 16'h0000)
        else $error("unmapped low address returned data");
    a_high_unmapped: assert property (clk_en && reg_rd
        && reg_addr > `ADDR_BUF_LAST |=> reg_rdata == 16'h0000)
        else $error("unmapped high address returned data");
    a_unlock_pair: assert property (
        unlock_pair ##1 then_status |=> reg_rdata[`STAT_WP_GLOBAL] == 1'b0)
        else $error("protection still on after unlock pair");
    a_active_after_cmd: assert property (
        st_rd ##1 reg_rdata[`STAT_NVM_ACTIVE] |-> since_cmd_r <= ACT_MAX)
        else $error("nvm active without a recent command");
endmodule // sha_auth_checker

bind sha_auth_secret_manager sha_auth_checker #(
    .HASH_CYC(HASH_CYC),
    .STORE_CYC(STORE_CYC)
) i_sha_auth_checker (.core_clk(core_clk), .arst_n(arst_n),
    .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .nvm_write_fail(nvm_write_fail));

// [bench/tb.sv]
`include "sha_auth_regs.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam HC = 8;
    localparam SC = 8;
    localparam [159:0] CA =
        160'h0123_4567_89AB_CDEF_1357_9BDF_2468_ACE0_F0E1_D2C3;
    localparam [159:0] SD =
        160'hA5A5_0F0F_3C3C_C3C3_F00D_1234_5678_9ABC_DEF0_7777;
    typedef struct {logic [8:0] a; logic [15:0] e;} row_t;
    row_t rows [6] = '{
        '{`ADDR_PROT_STAT, 16'h00F9},
        '{`ADDR_COMMAND, 16'h0000},
        '{`ADDR_BUF_FIRST, 16'h0000},
        '{`ADDR_BUF_LAST, 16'h0000},
        '{9'h062, 16'h0000},
        '{9'h0D0, 16'h0000}};
    logic [15:0] upd [4] = '{`CMD_NEXT_SERIAL, `CMD_NEXT_PLAIN,
        `CMD_NEXT_SERIAL, `CMD_CLEAR_SECRET};
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b0;
    logic nvm_write_fail = 1'b0;
    logic reg_wr, reg_rd;
    logic [8:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [255:0] m, m1, m2, mi;
    int fail_count = 0;
    int checks_done = 0;
    initial forever #2 core_clk = ~core_clk;
    host_ctl i_host_ctl (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    sha_auth_secret_manager #(.HASH_CYC(HC), .STORE_CYC(SC))
        i_sha_auth_secret_manager (.core_clk(core_clk), .arst_n(arst_n),
        .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .nvm_write_fail(nvm_write_fail));
    task chk(input [255:0] g, input [255:0] e, input bit eq);
        checks_done++;
        if ((g === e) != eq || $isunknown(g)) begin
            $display("BAD %0t got %h exp %h", $time, g, e);
            fail_count++;
        end
    endtask
    task fill(input [159:0] c);
        for (int k = 0; k < 10; k++)
            i_host_ctl.wr(9'(`ADDR_BUF_FIRST + k), c[159-16*k -: 16]);
    endtask
    task mac(output [255:0] o);
        for (int k = 0; k < 16; k++) begin
            i_host_ctl.rd(9'(`ADDR_BUF_FIRST + k), d);
            o[255-16*k -: 16] = d;
        end
    endtask
    task cmd(input [15:0] c, input int n);
        i_host_ctl.wr(`ADDR_COMMAND, c);
        repeat (n) @(posedge core_clk);
    endtask
    task stat(input [15:0] e);
        i_host_ctl.rd(`ADDR_PROT_STAT, d);
        chk(d, e, 1'b1);
    endtask
    task pair(input [15:0] v);
        i_host_ctl.wr(`ADDR_PROT_STAT, v);
        i_host_ctl.wr(`ADDR_PROT_STAT, v);
    endtask
    task imac(input bit spoil, input [15:0] ic, input [15:0] mc,
        output [255:0] o);
        cmd(`CMD_LOAD_INTER, 2);
        fill(SD);
        cmd(ic, HC + 2);
        fill(CA);
        if (spoil)
            cmd(`CMD_MAC_PLAIN, HC + 2);
        fill(CA);
        cmd(mc, HC + 2);
        mac(o);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
        foreach (rows[r]) begin
            i_host_ctl.rd(rows[r].a, d);
            chk(d, rows[r].e, 1'b1);
        end
        fill(CA);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m);
        chk(m[255:96], CA, 1'b1);
        pair(`STAT_UNLOCK_VAL);
        stat(16'h0000);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m1);
        chk(m1[255:96], CA, 1'b0);
        fill(CA);
        cmd(16'h1234, HC + 2);
        mac(m);
        chk(m[255:96], CA, 1'b1);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m);
        chk(m, m1, 1'b1);
        fill(SD);
        cmd(`CMD_NEXT_PLAIN, HC + 2);
        stat(16'h0002);
        repeat (SC) @(posedge core_clk);
        stat(16'h0000);
        mac(m);
        chk(m[255:96], SD, 1'b1);
        fill(CA);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m2);
        chk(m2, m1, 1'b0);
        nvm_write_fail <= 1'b1;
        cmd(`CMD_NEXT_SERIAL, HC + SC + 4);
        nvm_write_fail <= 1'b0;
        stat(16'h0004);
        i_host_ctl.wr(`ADDR_PROT_STAT, `STAT_UNLOCK_VAL);
        stat(16'h0000);
        fill(CA);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m);
        chk(m, m2, 1'b1);
        foreach (upd[u])
            cmd(upd[u], HC + SC + 4);
        fill(CA);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m);
        chk(m, m1, 1'b1);
        fill(SD);
        cmd(`CMD_NEXT_PLAIN, 4);
        stat(16'h0004);
        fill(CA);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m);
        chk(m, m1, 1'b1);
        imac(1'b0, `CMD_INTER_PLAIN, `CMD_IMAC_PLAIN, mi);
        chk(mi, m1, 1'b0);
        fill(CA);
        cmd(`CMD_IMAC_PLAIN, HC + 2);
        mac(m);
        chk(m, mi, 1'b0);
        imac(1'b0, `CMD_INTER_PLAIN, `CMD_IMAC_PLAIN, m);
        chk(m, mi, 1'b1);
        imac(1'b1, `CMD_INTER_PLAIN, `CMD_IMAC_PLAIN, m);
        chk(m, mi, 1'b0);
        imac(1'b0, `CMD_INTER_SERIAL, `CMD_IMAC_SERIAL, m);
        chk(m, mi, 1'b0);
        pair(`STAT_RELOCK_VAL);
        stat(16'h00F9);
        // Second reset mid-run: counters, secret and lock start over
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        stat(16'h00F9);
        pair(`STAT_UNLOCK_VAL);
        cmd(`CMD_LOCK_SECRET, 2);
        // Freeze mid-store: the store must resume, not finish on time
        clk_en <= 1'b0;
        repeat (20) @(posedge core_clk);
        clk_en <= 1'b1;
        stat(16'h0002);
        repeat (SC) @(posedge core_clk);
        stat(16'h0000);
        fill(SD);
        cmd(`CMD_NEXT_PLAIN, 4);
        stat(16'h0004);
        fill(CA);
        cmd(`CMD_MAC_PLAIN, HC + 2);
        mac(m);
        chk(m, m1, 1'b1);
        fill(CA);
        cmd(`CMD_MAC_SERIAL, HC + 2);
        mac(m);
        chk(m, m1, 1'b0);
        end_of_test;
    end
endmodule // tb

// [hdl/sha_auth_regs.vh]
`ifndef SHA_AUTH_REGS_VH
`define SHA_AUTH_REGS_VH

`define ADDR_COMMAND 9'h060
`define ADDR_PROT_STAT 9'h061
`define ADDR_BUF_FIRST 9'h0C0
`define ADDR_BUF_LAST 9'h0CF
`define ADDR_CHAL_LAST 9'h0C9

`define STAT_WP_GLOBAL 0
`define STAT_NVM_ACTIVE 1
`define STAT_NVM_FAIL 2
`define STAT_WP_LO 3
`define STAT_WP_HI 7
`define STAT_WP_RESET 5'h1F
`define STAT_UNLOCK_VAL 16'h0000
`define STAT_RELOCK_VAL 16'h00F9

`define CMD_MAC_SERIAL 16'h3500
`define CMD_MAC_PLAIN 16'h3600
`define CMD_NEXT_PLAIN 16'h3000
`define CMD_NEXT_SERIAL 16'h3300
`define CMD_CLEAR_SECRET 16'h5A00
`define CMD_LOCK_SECRET 16'h6000
`define CMD_LOAD_INTER 16'h3800
`define CMD_INTER_SERIAL 16'h3900
`define CMD_INTER_PLAIN 16'h3A00
`define CMD_IMAC_SERIAL 16'h3D00
`define CMD_IMAC_PLAIN 16'h3C00

`define SECRET_RESET 160'h0
`define SERIAL_MASK_ONES 64'hFFFFFFFFFFFFFFFF

`define CLK_PERIOD_NS 4
`define HASH_WAIT_NS 4000
`define NVM_STORE_NS 16000
`define HASH_WAIT_CYC (`HASH_WAIT_NS / `CLK_PERIOD_NS)
`define NVM_STORE_CYC ((`NVM_STORE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECRET_LIMIT 6

`endif

// [hdl/sha_auth_secret_manager.v]
// Behaviour
// - 3600h hashes challenge 0C0h-0C9h; digest read at 0C0h-0CFh.
// - No direct secret write; new secret hashed from old one and seed.
// - Secret changes, clears included, capped at limit; then refused.
// - Failed update keeps old secret but still uses one update.
// - New device holds an all-zero secret.
// - 3300h/3000h at 060h derive new secret from secret and seed.
// - Failed update sets fail flag; host restarts from the unlock.
// - 6000h locks the secret until reset; host waits the store time.
// - 3800h loads intermediate secret from NVM into working RAM.
// - 3900h/3A00h derive next intermediate secret from it and seed.
// - 3D00h/3C00h MAC intermediate secret and challenge into 0C0h-0CFh.
// - Ordinary MAC or derivation overwrites the intermediate secret.
// - Intermediate MAC destroys it; host rebuilds it each time.
// - Every computed MAC replaces the challenge in 0C0h-0CFh.
// - Derivation keeps last 160 hash bits; buffer left unchanged.
// - Active flag rises when a nonvolatile store starts, clears when done.
`include "sha_auth_regs.vh"

module sha_auth_secret_manager #(
    parameter HASH_CYC = `HASH_WAIT_CYC,
    parameter STORE_CYC = `NVM_STORE_CYC,
    parameter [3:0] SECRET_UPDATE_LIMIT = `SECRET_LIMIT,
    // Arbitrary values, no meaning outside simulation
    parameter [63:0] UNIQUE_SERIAL_NUMBER = 64'h0123456789ABCDEF,
    parameter [159:0] NV_INTER_SECRET = 160'h5A5A5A5A00000000A5A5A5A5
) (
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    input wire reg_wr,
    input wire reg_rd,
    input wire [8:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire nvm_write_fail
);
    localparam S_IDLE = 3'b001;
    localparam S_HASH = 3'b010;
    localparam S_STORE = 3'b100;

    localparam K_MAC = 3'd0;
    localparam K_NEXT = 3'd1;
    localparam K_CLEAR = 3'd2;
    localparam K_LOCK = 3'd3;
    localparam K_INTER = 3'd4;
    localparam K_IMAC = 3'd5;

    reg [2:0] state_r;
    reg [2:0] kind_r;
    reg [15:0] cnt_r;
    reg [255:0] mix_r;
    reg [15:0] buf_r [0:15];
    reg [159:0] secret_r;
    reg [159:0] inter_r;
    reg [3:0] used_r;
    reg secret_locked_r;
    reg wp_global_r;
    reg [4:0] wp_pages_r;
    reg nvm_fail_flag_r;
    reg pair_armed_r;
    reg [15:0] pair_val_r;

    wire idle = (state_r == S_IDLE);
    wire wr_cmd = reg_wr && reg_addr == `ADDR_COMMAND;
    wire wr_stat = reg_wr && reg_addr == `ADDR_PROT_STAT;
    wire in_buf = reg_addr >= `ADDR_BUF_FIRST && reg_addr <= `ADDR_BUF_LAST;
    wire [3:0] buf_idx = reg_addr[3:0];
    wire cmd_ok = wr_cmd && idle && !wp_global_r;

    // Decodes a command word: bit 4 valid, bit 3 serial, low bits the kind
    function [4:0] decode;
        input [15:0] code;
        begin
            case (code)
                `CMD_MAC_PLAIN: decode = {2'b10, K_MAC};
                `CMD_MAC_SERIAL: decode = {2'b11, K_MAC};
                `CMD_NEXT_PLAIN: decode = {2'b10, K_NEXT};
                `CMD_NEXT_SERIAL: decode = {2'b11, K_NEXT};
                `CMD_CLEAR_SECRET: decode = {2'b10, K_CLEAR};
                `CMD_LOCK_SECRET: decode = {2'b10, K_LOCK};
                `CMD_LOAD_INTER: decode = {2'b10, K_INTER};
                `CMD_INTER_PLAIN: decode = {2'b10, K_INTER};
                `CMD_INTER_SERIAL: decode = {2'b11, K_INTER};
                `CMD_IMAC_PLAIN: decode = {2'b10, K_IMAC};
                `CMD_IMAC_SERIAL: decode = {2'b11, K_IMAC};
                default: decode = 5'h00;
            endcase
        end
    endfunction

    wire [4:0] dec = decode(reg_wdata);
    wire dec_valid = dec[4];
    wire [63:0] serial_word = dec[3] ? UNIQUE_SERIAL_NUMBER
                                     : `SERIAL_MASK_ONES;
    wire is_load = reg_wdata == `CMD_LOAD_INTER;
    wire is_nv_kind = dec[2:0] == K_NEXT || dec[2:0] == K_CLEAR ||
                      dec[2:0] == K_LOCK;

    wire [159:0] chal;
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_chal
            assign chal[159 - 16 * gi -: 16] = buf_r[gi];
        end
    endgenerate

    wire [159:0] hash_key = (dec[2:0] == K_INTER || dec[2:0] == K_IMAC)
                            ? inter_r : secret_r;
    wire [255:0] mix_seed = {hash_key, chal[159:64]} ^
                            {chal[63:0], serial_word, 128'h0};

    // Compact round: rotate the state and fold one mixed word back in.
    // Keeps the timing and data paths of the engine; not a standard digest.
    wire [31:0] fold = {mix_r[226:224], mix_r[255:227]} + mix_r[127:96];
    wire [255:0] mix_nxt = {mix_r[223:0], mix_r[255:224] ^ fold ^
                            {16'h0000, cnt_r} ^ 32'h428A2F98};

    wire change_ok = used_r < SECRET_UPDATE_LIMIT && !secret_locked_r;
    wire pages_open = !wp_global_r || !reg_wdata[`STAT_WP_GLOBAL];

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            if (!reg_rd) begin
                reg_rdata <= 16'h0000;
            end else if (reg_addr == `ADDR_PROT_STAT) begin
                reg_rdata <= {8'h00, wp_pages_r, nvm_fail_flag_r,
                              state_r == S_STORE, wp_global_r};
            end else if (in_buf) begin
                reg_rdata <= buf_r[buf_idx];
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // Protection writes take effect only on two equal writes back to back
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pair_armed_r <= 1'b0;
            pair_val_r <= 16'h0000;
            wp_global_r <= 1'b1;
            wp_pages_r <= `STAT_WP_RESET;
        end else if (clk_en) begin
            if (wr_stat) begin
                pair_val_r <= reg_wdata;
                pair_armed_r <= !(pair_armed_r && pair_val_r == reg_wdata);
                if (pair_armed_r && pair_val_r == reg_wdata) begin
                    wp_global_r <= reg_wdata[`STAT_WP_GLOBAL];
                    if (pages_open)
                        wp_pages_r <= reg_wdata[`STAT_WP_HI:`STAT_WP_LO];
                end
            end else if (reg_wr || reg_rd) begin
                pair_armed_r <= 1'b0;
            end
        end
    end

    integer i;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
            kind_r <= K_MAC;
            cnt_r <= 16'h0000;
            mix_r <= 256'h0;
            secret_r <= `SECRET_RESET;
            inter_r <= 160'h0;
            used_r <= 4'h0;
            secret_locked_r <= 1'b0;
            nvm_fail_flag_r <= 1'b0;
            for (i = 0; i < 16; i = i + 1)
                buf_r[i] <= 16'h0000;
        end else if (clk_en) begin
            // Host may clear the fail flag once protection is off
            if (wr_stat && !wp_global_r && !reg_wdata[`STAT_NVM_FAIL])
                nvm_fail_flag_r <= 1'b0;
            // Buffer is frozen while the engine owns it
            if (reg_wr && in_buf && idle)
                buf_r[buf_idx] <= reg_wdata;
            case (state_r)
                S_IDLE: begin
                    if (cmd_ok && dec_valid) begin
                        kind_r <= dec[2:0];
                        cnt_r <= 16'h0000;
                        mix_r <= mix_seed;
                        if (is_load) begin
                            inter_r <= NV_INTER_SECRET;
                        end else if (is_nv_kind && !change_ok) begin
                            nvm_fail_flag_r <= 1'b1;
                        end else if (dec[2:0] == K_CLEAR ||
                                     dec[2:0] == K_LOCK) begin
                            state_r <= S_STORE;
                        end else begin
                            state_r <= S_HASH;
                        end
                    end
                end
                S_HASH: begin
                    mix_r <= mix_nxt;
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == HASH_CYC[15:0] - 16'h0001) begin
                        cnt_r <= 16'h0000;
                        // Working RAM is reused by every hash pass
                        inter_r <= 160'h0;
                        case (kind_r)
                            K_MAC, K_IMAC: begin
                                for (i = 0; i < 16; i = i + 1)
                                    buf_r[i] <= mix_nxt[255 - 16 * i -: 16];
                                state_r <= S_IDLE;
                            end
                            K_INTER: begin
                                inter_r <= mix_nxt[159:0];
                                state_r <= S_IDLE;
                            end
                            default: begin
                                state_r <= S_STORE;
                            end
                        endcase
                    end
                end
                S_STORE: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == STORE_CYC[15:0] - 16'h0001) begin
                        state_r <= S_IDLE;
                        if (kind_r != K_LOCK)
                            used_r <= used_r + 4'h1;
                        if (nvm_write_fail) begin
                            nvm_fail_flag_r <= 1'b1;
                        end else if (kind_r == K_LOCK) begin
                            secret_locked_r <= 1'b1;
                        end else if (kind_r == K_CLEAR) begin
                            secret_r <= `SECRET_RESET;
                        end else begin
                            secret_r <= mix_r[159:0];
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // sha_auth_secret_manager
